// [cfdm_fault_cfg.sv]
// Purpose: fault qualify/release/hold, shadow config and status word
// Assumes: one request per cycle; answer one cycle later
// Notes:   seen bits clear on an accepted status read
`timescale 1ns/1ps
module cfdm_fault_cfg #(
    parameter int CNT_W = 10
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire cfdm_pkg::cfdm_req_t   req_i,
    input  wire logic [25:0]           nv_a_i,
    input  wire logic [25:0]           nv_b_i,
    input  wire logic [25:0]           nv_c_i,
    input  wire logic [6:0]            level_pos_i,
    input  wire logic [6:0]            level_neg_i,
    input  wire logic [11:0]           temp_code_i,
    input  wire logic                  low_supply_i,
    input  wire logic                  high_supply_i,
    output logic                       fault_n,
    output logic                       fault_pullup_en,
    output cfdm_pkg::cfdm_cfg_a_t      cfg_a_o,
    output cfdm_pkg::cfdm_cfg_b_t      cfg_b_o,
    output cfdm_pkg::cfdm_rsp_t        rsp_o,
    output cfdm_pkg::cfdm_nvw_t        nvw_o
);
    import cfdm_pkg::*;

    if ((2 ** CNT_W) <= BASE_CYC + cyc_up(QUAL_ADD_NS[7]) || (2 ** CNT_W) <= REL_CYC)
    begin : g_chk
        $error("CNT_W too small for the qualify or release counts");
    end

    typedef struct packed {
        cfdm_mode_t                  mode;
        cfdm_cfg_a_t                 cfg_a;
        cfdm_cfg_b_t                 cfg_b;
        logic [1:0][CNT_W-1:0]       qual_cnt;
        logic [1:0][CNT_W-1:0]       rel_cnt;
        logic [1:0]                  oc_side;
        logic                        ot_flag;
        logic                        held;
        logic [4:0]                  seen;
        logic                        fault_n;
        logic                        pullup_en;
        cfdm_rsp_t                   rsp;
        cfdm_nvw_t                   nvw;
    } cfdm_state_t;

    cfdm_state_t s_q;
    cfdm_state_t s_d;

    // margin in percent, clipped so release stays at or above 25 %
    function automatic logic [6:0] hyst_eff(input logic [6:0] trip, input logic [1:0] code);
        logic [6:0] h;
        logic [6:0] lim;
        h   = 7'(HYST_PCT[code]);
        lim = (trip > 7'(HYST_FLOOR_PCT)) ? trip - 7'(HYST_FLOOR_PCT) : 7'h00;
        return (h > lim) ? lim : h;
    endfunction : hyst_eff

    function automatic logic [CNT_W-1:0] qual_target(input logic [2:0] code);
        // code 0 adds nothing, so the added part is rounded up without a one-cycle floor
        return CNT_W'(BASE_CYC + (QUAL_ADD_NS[code] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction : qual_target

    // one bit wider than the code: the top levels lie beyond 12 bits and must stay unreachable
    function automatic logic [12:0] ot_code(input logic [3:0] lvl);
        int c;
        c = OT_BASE_C + OT_STEP_C * int'(lvl) - TEMP_REF_C;
        return 13'(TEMP_ZERO_CODE + (c * 27) / 2);
    endfunction : ot_code

    logic [1:0]   over;
    logic [1:0]   below;
    logic         ot_over;
    logic         accepted;
    logic         clr_seen;
    logic [4:0]   now_bits;
    cfdm_status_t status;

    always_comb
    begin
        status                 = '0;
        status.temperature     = temp_code_i;
        status.low_supply_now  = low_supply_i;
        status.high_supply_now = high_supply_i;
        status.overcurrent_now = |s_q.oc_side;
        status.overheat_now    = s_q.ot_flag;
        status.fault_pin_now   = !s_q.fault_n;
        status.seen            = s_q.seen;
        now_bits = {low_supply_i, high_supply_i, |s_q.oc_side, s_q.ot_flag, !s_q.fault_n};
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        logic [6:0] trip;
        logic [6:0] lvl;
        logic       dis;
        trip      = '0;
        lvl       = '0;
        dis       = 1'b0;
        s_d       = s_q;
        s_d.rsp   = '0;
        s_d.nvw   = '0;
        clr_seen  = 1'b0;
        over      = '0;
        below     = '0;
        accepted  = req_i.valid && (req_i.via_prog_pin || !s_q.cfg_a.com_lock);
        case (s_q.mode)
            MODE_LOAD:
            begin
                s_d.cfg_a = cfdm_cfg_a_t'(nv_a_i);
                s_d.cfg_b = cfdm_cfg_b_t'(nv_b_i);
                s_d.mode  = MODE_RUN;
            end
            MODE_RUN:
            begin
                if (req_i.valid)
                begin
                    s_d.rsp.valid   = 1'b1;
                    s_d.rsp.refused = !accepted;
                end
                if (accepted)
                begin
                    case (req_i.addr)
                        ADDR_NV_A, ADDR_NV_B, ADDR_NV_C:
                        begin
                            if (req_i.write)
                            begin
                                if (s_q.cfg_a.write_lock)
                                    s_d.rsp.refused = 1'b1;
                                else
                                begin
                                    s_d.nvw.valid = 1'b1;
                                    s_d.nvw.addr  = req_i.addr;
                                    s_d.nvw.data  = req_i.wdata;
                                end
                            end
                            else if (req_i.addr == ADDR_NV_A)
                                s_d.rsp.rdata = {2'b00, nv_a_i};
                            else if (req_i.addr == ADDR_NV_B)
                                s_d.rsp.rdata = {2'b00, nv_b_i};
                            else
                                s_d.rsp.rdata = {2'b00, nv_c_i};
                        end
                        ADDR_SH_A:
                        begin
                            if (req_i.write)
                                s_d.cfg_a = cfdm_cfg_a_t'(req_i.wdata);
                            else
                                s_d.rsp.rdata = {2'b00, s_q.cfg_a};
                        end
                        ADDR_SH_B:
                        begin
                            if (req_i.write)
                                s_d.cfg_b = cfdm_cfg_b_t'(req_i.wdata);
                            else
                                s_d.rsp.rdata = {2'b00, s_q.cfg_b};
                        end
                        ADDR_STATUS:
                        begin
                            if (req_i.write)
                                s_d.rsp.refused = 1'b1;
                            else
                            begin
                                s_d.rsp.rdata = status;
                                clr_seen      = 1'b1;
                            end
                        end
                        default: s_d.rsp.refused = 1'b1;
                    endcase
                end
            end
            default: s_d.mode = MODE_LOAD;
        endcase

        // side 0 positive, side 1 negative, each on its own trip
        for (int i = 0; i < 2; i++)
        begin
            trip = (i == 0) ? s_q.cfg_b.positive_trip_level : s_q.cfg_b.negative_trip_level;
            lvl  = (i == 0) ? level_pos_i : level_neg_i;
            dis  = (i == 0) ? s_q.cfg_b.positive_trip_disable
                            : s_q.cfg_b.negative_trip_disable;
            over[i]  = !dis && (s_q.mode == MODE_RUN) && (lvl >= trip);
            below[i] = lvl < (trip - hyst_eff(trip, s_q.cfg_b.overcurrent_release_margin));
            if (!s_q.oc_side[i])
            begin
                s_d.rel_cnt[i] = '0;
                if (!over[i])
                    s_d.qual_cnt[i] = '0;
                else if (s_q.qual_cnt[i] >= qual_target(s_q.cfg_b.overcurrent_qualify_delay) - 1'b1)
                begin
                    s_d.oc_side[i]  = 1'b1;
                    s_d.qual_cnt[i] = '0;
                end
                else
                    s_d.qual_cnt[i] = s_q.qual_cnt[i] + 1'b1;
            end
            else if ((below[i] || dis) && !s_q.cfg_b.hold_enable && !s_q.held)
            begin
                if (s_q.rel_cnt[i] >= CNT_W'(REL_CYC - 1))
                begin
                    s_d.oc_side[i] = 1'b0;
                    s_d.rel_cnt[i] = '0;
                end
                else
                    s_d.rel_cnt[i] = s_q.rel_cnt[i] + 1'b1;
            end
            else
                s_d.rel_cnt[i] = '0;
        end

        ot_over = !s_q.cfg_a.overheat_detect_disable && (s_q.mode == MODE_RUN)
                  && ({1'b0, temp_code_i} >= ot_code(s_q.cfg_b.overheat_trip_level));
        if (ot_over)
            s_d.ot_flag = 1'b1;
        else if (!s_q.cfg_b.hold_enable && !s_q.held)
            s_d.ot_flag = 1'b0;

        s_d.held = s_q.held | (s_q.cfg_b.hold_enable & (|s_d.oc_side | s_d.ot_flag));
        s_d.fault_n   = !((|s_d.oc_side | s_d.ot_flag | s_d.held)
                          && !s_q.cfg_a.fault_output_disable);
        s_d.pullup_en = !s_q.cfg_a.fault_pullup_detach;
        // a new occurrence beats the clear of the read
        s_d.seen = (clr_seen ? 5'h00 : s_q.seen) | now_bits;
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            s_q           <= '0;
            s_q.mode      <= MODE_LOAD;
            s_q.cfg_a     <= CFG_A_RESET;
            s_q.cfg_b     <= CFG_B_RESET;
            s_q.fault_n   <= 1'b1;
            s_q.pullup_en <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign fault_n         = s_q.fault_n;
    assign fault_pullup_en = s_q.pullup_en;
    assign cfg_a_o         = s_q.cfg_a;
    assign cfg_b_o         = s_q.cfg_b;
    assign rsp_o           = s_q.rsp;
    assign nvw_o           = s_q.nvw;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence sh_b_write_s;
        s_q.mode == MODE_RUN && req_i.valid && req_i.write && req_i.addr == ADDR_SH_B
        && (req_i.via_prog_pin || !s_q.cfg_a.com_lock);
    endsequence
    sequence nv_locked_write_s;
        s_q.mode == MODE_RUN && req_i.valid && req_i.write && s_q.cfg_a.write_lock
        && (req_i.addr == ADDR_NV_A || req_i.addr == ADDR_NV_B || req_i.addr == ADDR_NV_C)
        && (req_i.via_prog_pin || !s_q.cfg_a.com_lock);
    endsequence
    sequence run_req_s;
        s_q.mode == MODE_RUN && req_i.valid;
    endsequence

    hold_keeps_fault_a: assert property ((s_q.held && !s_q.cfg_a.fault_output_disable) [*3]
        |=> !fault_n) else $error("held fault released");
    hold_latch_a: assert property (s_q.cfg_b.hold_enable && (|s_q.oc_side) |=> s_q.held)
        else $error("fault not held");
    hold_default_a: assert property ($rose(reset_n) |-> !s_q.held)
        else $error("hold active after reset");
    fault_low_a: assert property ((|s_q.oc_side) && !$past(s_q.cfg_a.fault_output_disable)
        |-> !fault_n) else $error("fault not driven low");
    fault_disable_a: assert property (s_q.cfg_a.fault_output_disable |=> fault_n)
        else $error("disabled fault pin driven low");
    release_delay_a: assert property ($fell(s_q.oc_side[0]) |->
        $past(s_q.rel_cnt[0]) == CNT_W'(REL_CYC - 1)) else $error("release delay wrong");
    neg_release_a: assert property ($fell(s_q.oc_side[1]) |->
        $past(s_q.rel_cnt[1]) == CNT_W'(REL_CYC - 1)) else $error("negative release delay wrong");
    qualify_time_a: assert property ($rose(s_q.oc_side[0]) |-> $past(s_q.qual_cnt[0])
        == qual_target($past(s_q.cfg_b.overcurrent_qualify_delay)) - 1'b1)
        else $error("qualify time wrong");
    neg_qualify_a: assert property ($rose(s_q.oc_side[1]) |-> $past(s_q.qual_cnt[1])
        == qual_target($past(s_q.cfg_b.overcurrent_qualify_delay)) - 1'b1)
        else $error("negative qualify time wrong");
    qual_restart_a: assert property (!s_q.oc_side[0] && !over[0] |=> s_q.qual_cnt[0] == '0)
        else $error("qualify count kept");
    pos_disable_a: assert property (s_q.cfg_b.positive_trip_disable && !s_q.oc_side[0]
        |=> !s_q.oc_side[0]) else $error("disabled side tripped");
    neg_disable_a: assert property (s_q.cfg_b.negative_trip_disable && !s_q.oc_side[1]
        |=> !s_q.oc_side[1]) else $error("disabled negative side tripped");
    startup_copy_a: assert property (s_q.mode == MODE_LOAD |=> s_q.cfg_a == $past(nv_a_i)
        && s_q.cfg_b == $past(nv_b_i)) else $error("startup copy missing");
    shadow_write_a: assert property (sh_b_write_s |=> s_q.cfg_b == $past(req_i.wdata)
        && !nvw_o.valid) else $error("shadow write wrong");
    nv_lock_a: assert property (nv_locked_write_s |=> rsp_o.refused && !nvw_o.valid)
        else $error("locked write taken");
    answer_next_a: assert property (run_req_s |=> rsp_o.valid)
        else $error("request not answered");
    no_answer_a: assert property (!req_i.valid |=> !rsp_o.valid)
        else $error("answer without request");
    status_readonly_a: assert property (run_req_s ##0 (req_i.write && req_i.addr == ADDR_STATUS)
        |=> rsp_o.refused) else $error("status word written");
    ot_floor_a: assert property (temp_code_i < 12'(TEMP_ZERO_CODE) && !s_q.ot_flag
        |=> !s_q.ot_flag) else $error("overheat below threshold");
    seen_record_a: assert property ((|now_bits) |=> (s_q.seen & $past(now_bits)) == $past(now_bits))
        else $error("condition not recorded");
    pullup_detach_a: assert property (s_q.cfg_a.fault_pullup_detach |=> !fault_pullup_en)
        else $error("pull-up still attached");
    pullup_attach_a: assert property (!s_q.cfg_a.fault_pullup_detach |=> fault_pullup_en)
        else $error("pull-up not attached");
endmodule : cfdm_fault_cfg

// [cfdm_fault_cfg_bench.sv]
// Purpose: self-checking bench for the fault and config block
// Assumes: nonvolatile array modelled by cfdm_nv_model
// Notes:   register answers checked against a queue of expected words
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module cfdm_fault_cfg_bench;
    import cfdm_pkg::*;
    localparam logic [29:0] WR  = 30'h2000_0000;
    localparam logic [29:0] REF = 30'h1000_0000;
    logic         clk = 1'b0;
    logic         reset_n = 1'b0;
    cfdm_req_t    req = '0;
    logic [6:0]   lv_p = 7'h00;
    logic [6:0]   lv_n = 7'h00;
    logic [11:0]  temp = 12'h000;
    logic         low_s = 1'b1;
    logic         high_s = 1'b0;
    logic         fault_n;
    logic         pu_en;
    cfdm_cfg_a_t  cfg_a;
    cfdm_cfg_b_t  cfg_b;
    cfdm_rsp_t    rsp;
    cfdm_nvw_t    nvw;
    logic [25:0]  nv_a, nv_b, nv_c, d;
    logic [29:0]  expq[$];
    logic [29:0]  ex;
    int           miscompares = 0;
    int           checked = 0;
    int           cyc = 0;
    int           trip, mg, q, side, th;

    always #12.5 clk = ~clk;

    cfdm_nv_model u_nv (.clk(clk), .nvw_i(nvw), .nv_a_o(nv_a), .nv_b_o(nv_b), .nv_c_o(nv_c));

    cfdm_fault_cfg #(.CNT_W(10)) u_dut (.clk(clk), .reset_n(reset_n), .req_i(req),
        .nv_a_i(nv_a), .nv_b_i(nv_b), .nv_c_i(nv_c), .level_pos_i(lv_p), .level_neg_i(lv_n),
        .temp_code_i(temp), .low_supply_i(low_s), .high_supply_i(high_s), .fault_n(fault_n),
        .fault_pullup_en(pu_en), .cfg_a_o(cfg_a), .cfg_b_o(cfg_b), .rsp_o(rsp), .nvw_o(nvw));

    task automatic final_report();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : wt

    // one register access; e holds {write, refused, rdata}
    task automatic acc(input logic wr, input logic pp, input logic [5:0] a,
                       input logic [25:0] v, input logic [29:0] e);
        req = '{1'b1, wr, pp, a, v};
        expq.push_back(e);
        wt(1);
        req = '0;
        wt(1);
    endtask : acc

    task automatic drv(input int s, input int v);
        if (s == 1)
            lv_n = 7'(v);
        else
            lv_p = 7'(v);
    endtask : drv

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            miscompares++;
            final_report();
        end
    end

    always @(posedge clk)
    begin
        if (rsp.valid === 1'b1)
        begin
            ex = expq.pop_front();
            `CHK("refused", ex[28], rsp.refused)
            if (ex[29] == 1'b0)
                `CHK("rdata", ex[27:0], rsp.rdata)
        end
    end

    initial
    begin
        void'($urandom(63872));
        temp = 12'($urandom % 4096);
        wt(1);
        `CHK("hold_rst", 1'b0, cfg_b.hold_enable)
        wt(1);
        reset_n = 1'b1;
        wt(1);
        `CHK("cfg_a_load", nv_a, cfg_a)
        `CHK("cfg_b_load", nv_b, cfg_b)
        `CHK("fault_idle", 1'b1, fault_n)
        acc(1'b0, 1'b0, ADDR_STATUS, 26'h000_0000, {2'b00, temp, 16'h1010});
        low_s = 1'b0;
        wt(2);
        acc(1'b0, 1'b0, ADDR_STATUS, 26'h000_0000, {2'b00, temp, 16'h0010});
        acc(1'b0, 1'b0, ADDR_STATUS, 26'h000_0000, {2'b00, temp, 16'h0000});
        acc(1'b1, 1'b0, ADDR_STATUS, 26'h000_0000, REF);
        acc(1'b0, 1'b0, 6'h3f, 26'h000_0000, REF);
        d = 26'($urandom);
        acc(1'b1, 1'b0, ADDR_NV_C, d, WR);
        acc(1'b0, 1'b0, ADDR_NV_C, d, {4'h0, d});
        d = 26'($urandom) | 26'h000_3fff;
        acc(1'b1, 1'b0, ADDR_SH_B, d, WR);
        `CHK("cfg_b_wr", d, cfg_b)
        acc(1'b0, 1'b0, ADDR_NV_B, d, {4'h0, nv_b});
        acc(1'b1, 1'b1, ADDR_SH_A, 26'h240_0000, WR);
        acc(1'b1, 1'b1, ADDR_NV_C, d, REF);
        acc(1'b1, 1'b1, ADDR_SH_A, 26'h140_0000, WR);
        acc(1'b0, 1'b0, ADDR_SH_A, 26'h000_0000, REF);
        acc(1'b0, 1'b1, ADDR_SH_A, 26'h000_0000, 30'h0140_0000);
        acc(1'b1, 1'b1, ADDR_SH_A, 26'h044_0000, WR);
        `CHK("pullup_off", 1'b0, pu_en)
        acc(1'b1, 1'b1, ADDR_SH_A, 26'h040_0000, WR);
        `CHK("pullup_on", 1'b1, pu_en)
        for (int c = 0; c < 8; c++)
        begin
            trip = 26 + ($urandom % 100);
            mg = (HYST_PCT[c % 4] > trip - 25) ? trip - 25 : HYST_PCT[c % 4];
            q = 100 + (QUAL_ADD_NS[c] + 24) / 25;
            side = c % 2;
            acc(1'b1, 1'b0, ADDR_SH_B, {2'(c % 4), 3'b000, 3'(c), 4'h0, 7'(trip), 7'(trip)}, WR);
            drv(side, trip);
            wt(q - 1);
            drv(side, 0);
            `CHK("short_spike", 1'b1, fault_n)
            wt(3);
            drv(side, trip);
            wt(q - 1);
            `CHK("qual_early", 1'b1, fault_n)
            wt(1);
            `CHK("qual_trip", 1'b0, fault_n)
            drv(side, trip - mg);
            wt(150);
            `CHK("at_margin", 1'b0, fault_n)
            drv(side, trip - mg - 1);
            wt(99);
            `CHK("rel_early", 1'b0, fault_n)
            wt(1);
            `CHK("released", 1'b1, fault_n)
            drv(side, 0);
        end
        acc(1'b1, 1'b0, ADDR_SH_B, {2'b00, 3'b010, 3'b000, 4'h0, 7'd50, 7'd50}, WR);
        drv(0, 127);
        wt(150);
        `CHK("pos_disabled", 1'b1, fault_n)
        drv(1, 60);
        wt(100);
        `CHK("neg_alive", 1'b0, fault_n)
        drv(1, 0);
        drv(0, 0);
        wt(100);
        th = TEMP_ZERO_CODE + ((OT_BASE_C + 2 * OT_STEP_C - TEMP_REF_C) * 27) / 2;
        temp = 12'(th - 1);
        acc(1'b1, 1'b0, ADDR_SH_B, {2'b00, 3'b000, 3'b000, 4'h2, 7'd127, 7'd127}, WR);
        acc(1'b1, 1'b0, ADDR_SH_A, 26'h000_0000, WR);
        `CHK("ot_below", 1'b1, fault_n)
        temp = 12'(th);
        high_s = 1'b1;
        wt(2);
        `CHK("ot_trip", 1'b0, fault_n)
        acc(1'b0, 1'b0, ADDR_STATUS, 26'h000_0000, {2'b00, temp, 16'h0b0f});
        temp = 12'(th - 1);
        high_s = 1'b0;
        wt(1);
        `CHK("ot_release", 1'b1, fault_n)
        acc(1'b1, 1'b0, ADDR_SH_B, {2'b00, 3'b000, 3'b000, 4'hf, 7'd127, 7'd127}, WR);
        temp = 12'hfff;
        wt(2);
        `CHK("ot_top_level", 1'b1, fault_n)
        acc(1'b1, 1'b0, ADDR_SH_A, 26'h040_0000, WR);
        acc(1'b1, 1'b0, ADDR_SH_B, {2'b00, 3'b100, 3'b000, 4'h0, 7'd50, 7'd50}, WR);
        drv(0, 60);
        wt(100);
        drv(0, 0);
        wt(300);
        `CHK("held", 1'b0, fault_n)
        d = 26'($urandom);
        acc(1'b1, 1'b0, ADDR_NV_B, d, WR);
        acc(1'b0, 1'b0, ADDR_NV_B, d, {4'h0, d});
        reset_n = 1'b0;
        wt(2);
        reset_n = 1'b1;
        wt(1);
        `CHK("power_cycle", 1'b1, fault_n)
        `CHK("reload_b", d, cfg_b)
        `CHK("pending", 0, expq.size())
        final_report();
    end
endmodule : cfdm_fault_cfg_bench

// [cfdm_nv_model.sv]
// Purpose: nonvolatile customer word array beside the fault and config block
// Assumes: write commands arrive as one-cycle pulses on nvw_i
// Notes:   contents persist across the block's power-on reset
`timescale 1ns/1ps
module cfdm_nv_model #(
    parameter logic [25:0] NV_A0 = 26'h040_0000,
    parameter logic [25:0] NV_B0 = 26'h000_3fff,
    parameter logic [25:0] NV_C0 = 26'h000_0000
) (
    input  wire logic                clk,
    input  wire cfdm_pkg::cfdm_nvw_t nvw_i,
    output logic [25:0]              nv_a_o,
    output logic [25:0]              nv_b_o,
    output logic [25:0]              nv_c_o
);
    import cfdm_pkg::*;

    initial
    begin
        nv_a_o = NV_A0;
        nv_b_o = NV_B0;
        nv_c_o = NV_C0;
    end

    // only explicit commands change the array, never shadow writes
    always @(posedge clk)
    begin
        if (nvw_i.valid === 1'b1)
        begin
            case (nvw_i.addr)
                ADDR_NV_A: nv_a_o <= nvw_i.data;
                ADDR_NV_B: nv_b_o <= nvw_i.data;
                ADDR_NV_C: nv_c_o <= nvw_i.data;
                default:   nv_c_o <= nv_c_o;
            endcase
        end
    end
endmodule : cfdm_nv_model

// [cfdm_pkg.sv]
// Purpose: constants and carriers for the fault and config block
// Assumes: 40 MHz clock; trip, margin and level inputs in 1 % steps
// Notes:   nonvolatile array sits outside the block
package cfdm_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int BASE_FAULT_NS = 2500;
    localparam int RELEASE_NS    = 2500;
    localparam int QUAL_ADD_NS [8] = '{0, 400, 2200, 4200, 6200, 8200, 10300, 12700};
    localparam int HYST_PCT [4]    = '{11, 22, 42, 75};
    localparam int HYST_FLOOR_PCT  = 25;
    localparam int OT_BASE_C       = 80;
    localparam int OT_STEP_C       = 7;
    localparam int TEMP_ZERO_CODE  = 2200;
    localparam int TEMP_REF_C      = 25;

    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    localparam int BASE_CYC = cyc_up(BASE_FAULT_NS);
    localparam int REL_CYC  = cyc_up(RELEASE_NS);

    localparam logic [5:0] ADDR_NV_A    = 6'h09;
    localparam logic [5:0] ADDR_NV_B    = 6'h0A;
    localparam logic [5:0] ADDR_NV_C    = 6'h0B;
    localparam logic [5:0] ADDR_SH_A    = 6'h19;
    localparam logic [5:0] ADDR_SH_B    = 6'h1A;
    localparam logic [5:0] ADDR_STATUS  = 6'h20;

    typedef enum logic {MODE_LOAD = 1'b0, MODE_RUN = 1'b1} cfdm_mode_t;

    typedef struct packed {
        logic       write_lock;
        logic       com_lock;
        logic       spare;
        logic       overheat_detect_disable;
        logic       output_sense_invert;
        logic       clamp_enable;
        logic       fault_output_disable;
        logic       fault_pullup_detach;
        logic [8:0] zero_field_offset_trim;
        logic [8:0] sensitivity_trim;
    } cfdm_cfg_a_t;

    typedef struct packed {
        logic [1:0] overcurrent_release_margin;
        logic       hold_enable;
        logic       positive_trip_disable;
        logic       negative_trip_disable;
        logic [2:0] overcurrent_qualify_delay;
        logic [3:0] overheat_trip_level;
        logic [6:0] negative_trip_level;
        logic [6:0] positive_trip_level;
    } cfdm_cfg_b_t;

    localparam cfdm_cfg_a_t CFG_A_RESET = 26'h000_0000;
    localparam cfdm_cfg_b_t CFG_B_RESET = 26'h000_0000;

    typedef struct packed {
        logic [11:0] temperature;
        logic [2:0]  rsvd_hi;
        logic        low_supply_now;
        logic        high_supply_now;
        logic        overcurrent_now;
        logic        overheat_now;
        logic        fault_pin_now;
        logic [2:0]  rsvd_lo;
        logic [4:0]  seen;
    } cfdm_status_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        via_prog_pin;
        logic [5:0]  addr;
        logic [25:0] wdata;
    } cfdm_req_t;

    typedef struct packed {
        logic        valid;
        logic        refused;
        logic [27:0] rdata;
    } cfdm_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [5:0]  addr;
        logic [25:0] data;
    } cfdm_nvw_t;
endpackage : cfdm_pkg
